// ### inc/esh_pkg.sv
// package for the exception syndrome and hypervisor configuration block
package esh_pkg;
	// register byte offsets on the apb slave
	localparam logic [11:0] OFF_SYN1     = 12'h000;
	localparam logic [11:0] OFF_SYN2     = 12'h004;
	localparam logic [11:0] OFF_SYN3     = 12'h008;
	localparam logic [11:0] OFF_HAUX     = 12'h00c;
	localparam logic [11:0] OFF_HCFG_LO  = 12'h010;
	localparam logic [11:0] OFF_HCFG_HI  = 12'h014;
	localparam logic [11:0] OFF_VSYN     = 12'h018;
	localparam logic [11:0] OFF_STATE    = 12'h01c;

	// syndrome field positions
	localparam int SYN_EC_LSB   = 26;
	localparam int SYN_IL_BIT   = 25;
	localparam int SYN_IDS_BIT  = 24;
	localparam int SYN_AET_LSB  = 10;
	localparam int SYN_EA_BIT   = 9;

	// hypervisor configuration bit positions
	localparam int HC_MISMATCH_NONCOHERENCY_ENABLE_BIT = 38;
	localparam int HC_RSVD_LSB    = 39;
	localparam int HC_RES1_BIT    = 31;
	localparam int HC_HCD_BIT     = 29;
	localparam int HC_TGE_BIT     = 27;
	localparam int HC_ID_GROUP3_TRAP_BIT    = 18;
	localparam int HC_AMO_BIT     = 5;
	localparam int HC_IMO_BIT     = 4;
	localparam int HC_FMO_BIT     = 3;

	// exception classes that force the length bit, data aborts only when syndrome bit 24 is clear
	localparam logic [5:0] EC_UNKNOWN   = 6'h00;
	localparam logic [5:0] EC_ILLEGAL   = 6'h0e;
	localparam logic [5:0] EC_PC_ALIGN  = 6'h22;
	localparam logic [5:0] EC_IABT_LO   = 6'h20;
	localparam logic [5:0] EC_IABT_CUR  = 6'h21;
	localparam logic [5:0] EC_DABT_LO   = 6'h24;
	localparam logic [5:0] EC_DABT_CUR  = 6'h25;
	localparam logic [5:0] EC_SP_ALIGN  = 6'h26;
	localparam logic [5:0] EC_SERROR    = 6'h2f;

	localparam logic [2:0] AET_UC  = 3'h0;
	localparam logic [2:0] AET_UEU = 3'h1;

	// exception entry request from the core
	typedef struct packed {
		logic [1:0]  level;
		logic [5:0]  ec;
		logic        il;
		logic [24:0] syndrome_info;
		logic        virt_serr;
	} esh_entry_t;

	// effective controls toward the core
	typedef struct packed {
		logic tge_eff;
		logic el1_mmu_eff;
		logic fmo_eff;
		logic imo_eff;
		logic amo_eff;
		logic virq_enable;
		logic id_group3_trap_eff;
		logic mismatch_noncoherency_enable;
	} esh_ctrl_t;
endpackage : esh_pkg

// ### rtl/esh_core.sv
// exception syndrome capture and hypervisor configuration registers
// Function
// - syndrome bits 31..26 hold the exception class
// - bit 25 gives instruction length, 0 = 16-bit, 1 = 32-bit
// - length reads 1 for serror, instruction aborts, data aborts with syndrome bit 24 clear, alignment, illegal state, class 0
// - virtual serror loads syndrome 24..0 from virtual syndrome register
// - physical serror forces implementation-syndrome flag to 0
// - physical serror error type is only uncontainable or unrecoverable
// - external abort type reads 0 for physical serror and sync data abort
// - syndrome registers are 32 bits, bits 24..0 carry syndrome
// - level 2/3 syndrome and hyp config have no defined reset value
// - hyp config is 64 bits, bits 63..39 read zero
// - bit 38 enables mismatched cacheable non-coherency
// - general trap with non-secure routes level 1 exceptions to level 2
// - general trap makes level 1 translation enable act as 0
// - general trap makes fiq, irq, serror routing act as 1
// - general trap disables all virtual interrupts
// - general trap makes exception return to level 1 illegal
// - secure state makes general trap act as 0 except direct access
// - general trap bit is never cached in tlb entries
// - id group 3 trap sends non-secure level 1 id reads to level 2
// - without level 2, hyp config reads zero from level 3
// - hyp auxiliary config is unused and reads zero
`timescale 1ns/1ps
module esh_core #(
	parameter bit EL2_PRESENT = 1'b1
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                srst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// core side
	input  wire logic                entry_valid,
	input  wire esh_pkg::esh_entry_t entry,
	input  wire logic                nonsecure,
	input  wire logic                el1_mmu_stored,
	input  wire logic                eret_valid,
	input  wire logic [1:0]          eret_target,
	input  wire logic                id3_read_el1,
	output logic [1:0]               entry_level_eff,
	output logic                     eret_illegal,
	output logic                     id3_trap,
	output esh_pkg::esh_ctrl_t       ctrl
);
	logic [31:0] syn_r [1:3];
	logic [63:0] hcfg_r;
	logic [24:0] vsyn_r;
	logic [31:0] syn_nxt;
	logic        tge_eff;
	logic        wr_en;
	logic [1:0]  lvl;
	logic [31:0] wmask;

	assign wr_en = psel & penable & pwrite;
	assign pready = 1'b1;
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// tge only counts in non-secure; stored value is still what software reads
	assign tge_eff = hcfg_r[esh_pkg::HC_TGE_BIT] & nonsecure;

	// tge is fed combinationally, so no translation entry ever holds a copy
	always_comb begin
		ctrl.tge_eff     = tge_eff;
		ctrl.el1_mmu_eff = el1_mmu_stored & ~tge_eff;
		ctrl.fmo_eff     = hcfg_r[esh_pkg::HC_FMO_BIT] | tge_eff;
		ctrl.imo_eff     = hcfg_r[esh_pkg::HC_IMO_BIT] | tge_eff;
		ctrl.amo_eff     = hcfg_r[esh_pkg::HC_AMO_BIT] | tge_eff;
		ctrl.virq_enable = ~tge_eff;
		ctrl.id_group3_trap_eff    = hcfg_r[esh_pkg::HC_ID_GROUP3_TRAP_BIT];
		ctrl.mismatch_noncoherency_enable     = hcfg_r[esh_pkg::HC_MISMATCH_NONCOHERENCY_ENABLE_BIT];
	end

	always_comb begin
		lvl = entry.level;
		if (tge_eff && entry.level == 2'd1) begin
			lvl = 2'd2;
		end
	end
	assign entry_level_eff = lvl;
	assign eret_illegal = eret_valid & tge_eff & (eret_target == 2'd1);
	assign id3_trap = id3_read_el1 & nonsecure & hcfg_r[esh_pkg::HC_ID_GROUP3_TRAP_BIT];

	// build the whole syndrome word in one go
	always_comb begin
		syn_nxt = {entry.ec, entry.il, entry.syndrome_info};
		unique case (entry.ec)
			esh_pkg::EC_UNKNOWN, esh_pkg::EC_ILLEGAL, esh_pkg::EC_PC_ALIGN,
			esh_pkg::EC_IABT_LO, esh_pkg::EC_IABT_CUR, esh_pkg::EC_SP_ALIGN,
			esh_pkg::EC_SERROR: begin
				syn_nxt[esh_pkg::SYN_IL_BIT] = 1'b1;
			end
			esh_pkg::EC_DABT_LO, esh_pkg::EC_DABT_CUR: begin
				syn_nxt[esh_pkg::SYN_EA_BIT] = 1'b0;
				if (!entry.syndrome_info[24]) begin
					syn_nxt[esh_pkg::SYN_IL_BIT] = 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (entry.ec == esh_pkg::EC_SERROR) begin
			if (entry.virt_serr) begin
				syn_nxt[24:0] = vsyn_r;
			end else begin
				syn_nxt[esh_pkg::SYN_IDS_BIT] = 1'b0;
				syn_nxt[esh_pkg::SYN_EA_BIT] = 1'b0;
				// only the two fatal types may be reported; fold others to uc
				if (entry.syndrome_info[esh_pkg::SYN_AET_LSB +: 3] != esh_pkg::AET_UEU) begin
					syn_nxt[esh_pkg::SYN_AET_LSB +: 3] = esh_pkg::AET_UC;
				end
			end
		end
	end

	// syndrome registers; entry has priority over a software write
	for (genvar g = 1; g <= 3; g++) begin : g_syn
		localparam logic [11:0] OFF = (g == 1) ? esh_pkg::OFF_SYN1 :
			(g == 2) ? esh_pkg::OFF_SYN2 : esh_pkg::OFF_SYN3;
		// no reset: level 1/2/3 values are undefined after reset
		always_ff @(posedge clk) begin
			if (entry_valid && lvl == 2'(g)) begin
				syn_r[g] <= syn_nxt;
			end else if (wr_en && paddr == OFF) begin
				syn_r[g] <= (syn_r[g] & ~wmask) | (pwdata & wmask);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en && paddr == esh_pkg::OFF_HCFG_LO) begin
			hcfg_r[31:0] <= (hcfg_r[31:0] & ~wmask) | (pwdata & wmask);
		end
		if (wr_en && paddr == esh_pkg::OFF_HCFG_HI) begin
			hcfg_r[63:32] <= (hcfg_r[63:32] & ~wmask) | (pwdata & wmask);
		end
		// reserved and fixed bits forced on every clock, write or not
		hcfg_r[63:esh_pkg::HC_RSVD_LSB] <= '0;
		hcfg_r[esh_pkg::HC_RES1_BIT] <= 1'b1;
		hcfg_r[esh_pkg::HC_HCD_BIT] <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			vsyn_r <= 25'h0000000;
		end else if (wr_en && paddr == esh_pkg::OFF_VSYN) begin
			vsyn_r <= (vsyn_r & ~wmask[24:0]) | (pwdata[24:0] & wmask[24:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			unique case (paddr)
				esh_pkg::OFF_SYN1: prdata <= syn_r[1];
				esh_pkg::OFF_SYN2: prdata <= syn_r[2];
				esh_pkg::OFF_SYN3: prdata <= syn_r[3];
				esh_pkg::OFF_HAUX: prdata <= 32'h00000000;
				esh_pkg::OFF_HCFG_LO: prdata <= EL2_PRESENT ? hcfg_r[31:0] : 32'h0;
				esh_pkg::OFF_HCFG_HI: prdata <= EL2_PRESENT ? hcfg_r[63:32] : 32'h0;
				esh_pkg::OFF_VSYN: prdata <= {7'h00, vsyn_r};
				esh_pkg::OFF_STATE: prdata <= {26'h0, tge_eff, lvl, entry_valid, 2'h0};
				default: begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end
endmodule : esh_core

// ### tb/esh_sva.sv
// concurrent checks on the syndrome and hypervisor configuration block ports
`timescale 1ns/1ps
module esh_sva (
	// clock and reset
	input logic                clk,
	input logic                srst,
	// apb
	input logic                psel,
	input logic                penable,
	input logic [11:0]         paddr,
	input logic [31:0]         prdata,
	// core side
	input logic                entry_valid,
	input esh_pkg::esh_entry_t entry,
	input logic                nonsecure,
	input logic                el1_mmu_stored,
	input logic                eret_valid,
	input logic [1:0]          eret_target,
	input logic                id3_read_el1,
	input logic [1:0]          entry_level_eff,
	input logic                eret_illegal,
	input logic                id3_trap,
	input esh_pkg::esh_ctrl_t  ctrl
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	a_route_el2: assert property (
		entry_valid && entry.level == 2'h1 && ctrl.tge_eff |-> entry_level_eff == 2'h2)
		else $error("level 1 entry not rerouted");
	a_secure_notrap: assert property (!nonsecure |-> !ctrl.tge_eff)
		else $error("trap active in secure state");
	a_mmu_masked: assert property (ctrl.tge_eff |-> !ctrl.el1_mmu_eff)
		else $error("translation enable not masked");
	a_mmu_pass: assert property (!ctrl.tge_eff |-> ctrl.el1_mmu_eff == el1_mmu_stored)
		else $error("translation enable not passed");
	a_route_ones: assert property (
		ctrl.tge_eff |-> ctrl.fmo_eff && ctrl.imo_eff && ctrl.amo_eff)
		else $error("routing bits not forced");
	a_virq_off: assert property (ctrl.tge_eff |-> !ctrl.virq_enable)
		else $error("virtual interrupts left on");
	a_eret_bad: assert property (
		eret_valid && eret_target == 2'h1 && ctrl.tge_eff |-> eret_illegal)
		else $error("return to level 1 allowed");
	a_id3_trap: assert property (id3_read_el1 && nonsecure |-> id3_trap == ctrl.id_group3_trap_eff)
		else $error("id read trap wrong");
	a_haux_zero: assert property (
		psel && !penable && paddr == 12'h00c |=> prdata == 32'h0)
		else $error("aux config not zero");
	c_reroute: cover property (entry_valid && entry_level_eff == 2'h2);
	c_eret: cover property (eret_valid && eret_illegal);
	c_id3: cover property (id3_read_el1 && id3_trap);
endmodule : esh_sva

// ### tb/tb.sv
// self-checking bench for the syndrome and hypervisor configuration block
`timescale 1ns/1ps
module tb;
	logic                clk = 1'b0, srst = 1'b1, pready, pslverr, e;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, entry_valid = 1'b0;
	logic                nonsecure = 1'b1, el1_mmu_stored = 1'b1, eret_valid = 1'b0;
	logic                id3_read_el1 = 1'b0, eret_illegal, id3_trap;
	logic [1:0]          eret_target = 2'h0, entry_level_eff;
	logic [3:0]          pstrb = 4'hf;
	logic [11:0]         paddr = 12'h0;
	logic [31:0]         pwdata = 32'h0, prdata, q;
	esh_pkg::esh_entry_t entry = '0;
	esh_pkg::esh_ctrl_t  ctrl;
	int                  error_cnt = 0, n_compared = 0, cyc = 0;
	logic [5:0]          ecs [8] = '{6'h00, 6'h0e, 6'h20, 6'h21, 6'h22, 6'h26, 6'h2f, 6'h24};
	esh_core esh_core_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .entry_valid, .entry, .nonsecure, .el1_mmu_stored,
		.eret_valid, .eret_target, .id3_read_el1, .entry_level_eff, .eret_illegal,
		.id3_trap, .ctrl);
	initial begin
		forever #2.5 clk = ~clk;
	end
	task print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// a hang is cut short well beyond the roughly 110 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	// il is always sent as 0 so forced lengths show up
	task ent(input logic [1:0] lv, input logic [5:0] c, input logic [24:0] s, input logic v);
		@(posedge clk);
		entry_valid <= 1'b1;
		entry <= '{lv, c, 1'b0, s, v};
		@(posedge clk);
		entry_valid <= 1'b0;
	endtask : ent
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		// routing bits stored as 0 so that the forcing under the trap is visible
		apb(1'b1, 12'h010, 32'hffffffc7);
		apb(1'b1, 12'h014, 32'hffffffff);
		rd(12'h010, 32'hdfffffc7);
		rd(12'h014, 32'h0000007f);
		chkb(ctrl.mismatch_noncoherency_enable, 1'b1);
		eret_valid <= 1'b1;
		eret_target <= 2'h1;
		id3_read_el1 <= 1'b1;
		@(negedge clk);
		chkb(ctrl.el1_mmu_eff, 1'b0);
		chk({29'h0, ctrl.fmo_eff, ctrl.imo_eff, ctrl.amo_eff}, 32'h7);
		chkb(ctrl.virq_enable, 1'b0);
		chkb(eret_illegal, 1'b1);
		chkb(id3_trap, 1'b1);
		ent(2'h1, 6'h15, 25'h123, 1'b0);
		rd(12'h004, {6'h15, 1'b0, 25'h123});
		nonsecure <= 1'b0;
		@(negedge clk);
		chkb(ctrl.tge_eff, 1'b0);
		chkb(eret_illegal, 1'b0);
		chkb(id3_trap, 1'b0);
		ent(2'h1, 6'h15, 25'h0aa, 1'b0);
		rd(12'h000, {6'h15, 1'b0, 25'h0aa});
		rd(12'h010, 32'hdfffffc7);
		nonsecure <= 1'b1;
		apb(1'b1, 12'h010, 32'h0);
		@(negedge clk);
		chkb(ctrl.el1_mmu_eff, 1'b1);
		chk({29'h0, ctrl.fmo_eff, ctrl.imo_eff, ctrl.amo_eff}, 32'h0);
		chkb(ctrl.virq_enable, 1'b1);
		chkb(eret_illegal, 1'b0);
		chkb(id3_trap, 1'b0);
		ent(2'h1, 6'h15, 25'h055, 1'b0);
		rd(12'h000, {6'h15, 1'b0, 25'h055});
		$display("test hyp_config done");
		for (int i = 0; i < 8; i++) begin
			ent(2'h3, ecs[i], 25'h200, 1'b0);
			rd(12'h008, {ecs[i], 1'b1, (i > 5) ? 25'h0 : 25'h200});
		end
		ent(2'h3, 6'h2f, 25'h1ffffff, 1'b0);
		rd(12'h008, {6'h2f, 1'b1, 25'h0ffe1ff});
		ent(2'h3, 6'h2f, 25'h400, 1'b0);
		rd(12'h008, {6'h2f, 1'b1, 25'h400});
		apb(1'b1, 12'h018, 32'h01555555);
		ent(2'h3, 6'h2f, 25'h0, 1'b1);
		rd(12'h008, {6'h2f, 1'b1, 25'h1555555});
		rd(12'h00c, 32'h0);
		// status: no trap, last entry level 3 still presented, no entry pending
		rd(12'h01c, 32'h00000018);
		apb(1'b0, 12'h040, 32'h0);
		chkb(e, 1'b1);
		$display("test syndrome done");
		print_verdict();
	end
endmodule : tb
bind esh_core esh_sva esh_sva_inst (.clk, .srst, .psel, .penable, .paddr, .prdata,
	.entry_valid, .entry, .nonsecure, .el1_mmu_stored, .eret_valid, .eret_target,
	.id3_read_el1, .entry_level_eff, .eret_illegal, .id3_trap, .ctrl);
